// File: hdl/btg_pkg.sv
// Shared constants and types of the badge terminal guidance block
// Operation
// - Ready lamp lit while a badge can be taken, off once fully inserted.
// - Wait lamp stays lit after a read until the host marks it processed.
// - When the wait lamp goes off, the ready lamp comes on next.
// - Wait lamp never lit while an operator fault is present; outside normal position the fault is ignored and a held wait lamp stays lit.
// - Operator fault lights the error lamp; the badge must be reinserted. Outside the normal position faults are ignored.
// - Three-position key switch selects normal, maintenance or supervisor behaviour.
// - Maintenance position starts one pass of the resident diagnostics.
// - Supervisor position qualifies user tasks or cycles diagnostics continuously.
// - Time of day shown as four digits, hours and minutes, 24-hour.
// - Each badge read is captured and handed to the host.
// - Multi-reader variant lights arrow and badge prompt together.
package btg_pkg;
	localparam int APB_AW = 8;
	localparam int INT_W = 4;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TIME = 8'h04;
	localparam logic [7:0] OFF_BADGE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_INT_STAT = 8'h10;
	localparam logic [7:0] OFF_INT_MASK = 8'h14;
	localparam int CTRL_DONE = 0;
	localparam int CTRL_CYCLE = 1;
	localparam int INT_BADGE = 0;
	localparam int INT_FAULT = 1;
	localparam int INT_TIME = 2;
	localparam int INT_DIAG = 3;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_KEY_LSB = 2;
	localparam int STAT_LAMP_LSB = 4;
	localparam int STAT_DIAG = 9;
	localparam int STAT_TASK = 10;
	localparam logic [15:0] TIME_RESET = 16'h0000;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;
	localparam logic CYCLE_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
	localparam logic [3:0] HOUR_UNITS_MAX_TWENTY = 4'h3;
	localparam logic [3:0] MIN_TENS_MAX = 4'h5;
	localparam logic [3:0] DIGIT_MAX = 4'h9;

	typedef enum logic [1:0] {
		btgReady = 2'b00,
		btgRead = 2'b01,
		btgWait = 2'b11,
		btgError = 2'b10
	} btg_state_type;

	typedef enum logic [1:0] {
		keyNormalPosition = 2'b00,
		keyMaintenancePosition = 2'b01,
		keySupervisorPosition = 2'b10
	} btg_key_type;

	typedef enum logic {
		dgIdle = 1'b0,
		dgRun = 1'b1
	} btg_diag_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} btg_apb_req_type;

	typedef struct packed {
		logic ready;
		logic waitInd;
		logic error;
		logic arrow;
		logic prompt;
	} btg_lamp_type;
endpackage

// File: hdl/btg_time_display.sv
// Time-of-day holding register with 24-hour digit check
`timescale 1ns/100ps
module btg_time_display
	import btg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic timeWr,
	input wire logic [15:0] timeIn,
	output logic [15:0] timeDigits,
	output logic timeReject
);
	typedef struct packed {
		logic [15:0] digits;
		logic reject;
	} btg_time_type;
	btg_time_type st, next_st;

	function automatic logic timeValid(input logic [15:0] t);
		logic ok;
		ok = (t[15:12] <= HOUR_TENS_MAX) && (t[11:8] <= DIGIT_MAX);
		ok = ok && !(t[15:12] == HOUR_TENS_MAX && t[11:8] > HOUR_UNITS_MAX_TWENTY);
		ok = ok && (t[7:4] <= MIN_TENS_MAX) && (t[3:0] <= DIGIT_MAX);
		return ok;
	endfunction

	always_comb begin
		next_st = st;
		next_st.reject = 1'b0;
		if (timeWr) begin
			if (timeValid(timeIn))
				next_st.digits = timeIn;
			else
				next_st.reject = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.digits <= TIME_RESET;
			st.reject <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign timeDigits = st.digits;
	assign timeReject = st.reject;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_time_hold: assert property (!timeWr |=> $stable(timeDigits))
		else $error("time changed without update");
	a_time_check: assert property (timeWr && !timeValid(timeIn) |=>
		timeReject && timeDigits == $past(timeDigits))
		else $error("invalid time accepted");
endmodule

// File: hdl/btg_diag_seq.sv
// Diagnostic run control from the key switch position
`timescale 1ns/100ps
module btg_diag_seq
	import btg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] keySwitch,
	input wire logic cycle,
	input wire logic diagDone,
	output logic diagStart,
	output logic diagActive,
	output logic taskQualify,
	output logic diagEvt
);
	typedef struct packed {
		btg_diag_state_type state;
		logic ran;
		logic start;
		logic evt;
	} btg_diag_type;
	btg_diag_type st, next_st;
	logic inMaint, inSuper, wantDiag;

	assign inMaint = keySwitch == keyMaintenancePosition;
	assign inSuper = keySwitch == keySupervisorPosition;
	assign wantDiag = inMaint || (inSuper && cycle);

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.evt = 1'b0;
		if (!inMaint)
			next_st.ran = 1'b0;
		case (st.state)
			dgIdle: begin
				if (wantDiag && !(inMaint && st.ran)) begin
					next_st.start = 1'b1;
					next_st.state = dgRun;
				end
			end
			dgRun: begin
				if (!wantDiag) begin
					next_st.state = dgIdle;
				end else if (diagDone) begin
					next_st.evt = 1'b1;
					if (inSuper) begin
						next_st.start = 1'b1;
					end else begin
						next_st.state = dgIdle;
						next_st.ran = 1'b1;
					end
				end
			end
			default: next_st.state = dgIdle;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.state <= dgIdle;
			st.ran <= 1'b0;
			st.start <= 1'b0;
			st.evt <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign diagStart = st.start;
	assign diagActive = st.state == dgRun;
	assign diagEvt = st.evt;
	assign taskQualify = inSuper && !cycle;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_maintenance_position_start: assert property (inMaint && !st.ran && !diagActive |=>
		diagStart && diagActive)
		else $error("maintenance did not start diagnostics");
	a_super_cycle: assert property (diagActive && diagDone && inSuper && cycle |=>
		diagStart && diagActive && diagEvt)
		else $error("supervisor cycling stopped");
endmodule

// File: hdl/btg_guidance_ctrl.sv
// Badge terminal guidance control with APB registers
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module btg_guidance_ctrl
	import btg_pkg::*;
#(
	parameter int BADGE_W = 32,
	parameter bit MULTI_READER = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire btg_apb_req_type apbReq,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [1:0] keySwitch,
	input wire logic badgeFull,
	input wire logic badgeFault,
	input wire logic badgeValid,
	input wire logic [BADGE_W-1:0] badgeData,
	input wire logic diagDone,
	output btg_lamp_type lamps,
	output logic [15:0] timeDigits,
	output logic diagStart,
	output logic diagActive,
	output logic taskQualify,
	output logic irq
);
	typedef struct packed {
		btg_state_type state;
		logic prevFull;
		logic [BADGE_W-1:0] badge;
		logic [INT_W-1:0] intStat;
		logic [INT_W-1:0] intMask;
		logic cycle;
		btg_lamp_type lamps;
		logic [31:0] rdData;
	} btg_main_type;
	btg_main_type st, next_st;

	logic setup;
	logic access;
	logic wrAccess;
	logic rdIntAccess;
	logic ackWr;
	logic timeWr;
	logic inNormal;
	logic mapped;
	logic faultEvt;
	logic badgeEvt;
	logic timeReject;
	logic diagEvt;
	logic [INT_W-1:0] intSet;
	logic [INT_W-1:0] intClr;
	logic [31:0] statusWord;

	// APB phases
	assign setup = apbReq.psel && !apbReq.penable;
	assign access = apbReq.psel && apbReq.penable;
	assign wrAccess = access && apbReq.pwrite;
	assign rdIntAccess = access && !apbReq.pwrite && apbReq.paddr == OFF_INT_STAT;
	assign ackWr = wrAccess && apbReq.paddr == OFF_CTRL && apbReq.pwdata[CTRL_DONE];
	assign timeWr = wrAccess && apbReq.paddr == OFF_TIME;

	always_comb begin
		case (apbReq.paddr)
			OFF_CTRL, OFF_TIME, OFF_BADGE, OFF_STATUS: mapped = 1'b1;
			OFF_INT_STAT, OFF_INT_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Badge handling only in normal position
	assign inNormal = keySwitch == keyNormalPosition;
	assign faultEvt = inNormal && badgeFault;
	assign badgeEvt = inNormal && !badgeFault && st.state == btgRead && badgeValid;

	always_comb begin
		intSet = '0;
		intSet[INT_BADGE] = badgeEvt;
		intSet[INT_FAULT] = faultEvt;
		intSet[INT_TIME] = timeReject;
		intSet[INT_DIAG] = diagEvt;
	end

	// Read clears only bits latched at setup
	assign intClr = rdIntAccess ? st.rdData[INT_W-1:0] : '0;

	always_comb begin
		statusWord = '0;
		statusWord[STAT_STATE_LSB +: 2] = st.state;
		statusWord[STAT_KEY_LSB +: 2] = keySwitch;
		statusWord[STAT_LAMP_LSB +: 5] = st.lamps;
		statusWord[STAT_DIAG] = diagActive;
		statusWord[STAT_TASK] = taskQualify;
	end

	always_comb begin
		next_st = st;
		next_st.prevFull = badgeFull;
		case (st.state)
			btgReady: begin
				if (inNormal && badgeFull && !st.prevFull)
					next_st.state = btgRead;
			end
			btgRead: begin
				if (badgeValid) begin
					next_st.badge = badgeData;
					next_st.state = btgWait;
				end else if (!badgeFull) begin
					next_st.state = btgReady;
				end
			end
			btgWait: begin
				if (ackWr)
					next_st.state = btgReady;
			end
			btgError: begin
				if (!badgeFull)
					next_st.state = btgReady;
			end
			default: next_st.state = btgReady;
		endcase
		if (faultEvt)
			next_st.state = btgError;
		else if (!inNormal && st.state != btgWait)
			next_st.state = btgReady;

		// Ready lamp off on full insertion
		next_st.lamps.ready = next_st.state == btgReady && inNormal && !badgeFull;
		next_st.lamps.waitInd = next_st.state == btgWait;
		next_st.lamps.error = next_st.state == btgError;
		next_st.lamps.arrow = MULTI_READER && next_st.lamps.ready;
		next_st.lamps.prompt = MULTI_READER && next_st.lamps.ready;

		// Sticky status, set wins over clear
		next_st.intStat = (st.intStat & ~intClr) | intSet;

		if (wrAccess && apbReq.paddr == OFF_INT_MASK)
			next_st.intMask = apbReq.pwdata[INT_W-1:0];
		if (wrAccess && apbReq.paddr == OFF_CTRL)
			next_st.cycle = apbReq.pwdata[CTRL_CYCLE];

		if (setup) begin
			case (apbReq.paddr)
				OFF_CTRL: next_st.rdData = 32'(st.cycle) << CTRL_CYCLE;
				OFF_TIME: next_st.rdData = 32'(timeDigits);
				OFF_BADGE: next_st.rdData = 32'(st.badge);
				OFF_STATUS: next_st.rdData = statusWord;
				OFF_INT_STAT: next_st.rdData = 32'(st.intStat);
				OFF_INT_MASK: next_st.rdData = 32'(st.intMask);
				default: next_st.rdData = RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.state <= btgReady;
			st.prevFull <= 1'b0;
			st.badge <= '0;
			st.intStat <= '0;
			st.intMask <= INT_MASK_RESET;
			st.cycle <= CYCLE_RESET;
			st.lamps <= '0;
			st.rdData <= RDATA_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = st.rdData;
	assign lamps = st.lamps;
	assign irq = |(st.intStat & st.intMask);

	btg_time_display u_time (
		.clk(clk),
		.resetn(resetn),
		.timeWr(timeWr),
		.timeIn(apbReq.pwdata[15:0]),
		.timeDigits(timeDigits),
		.timeReject(timeReject)
	);

	btg_diag_seq u_diag (
		.clk(clk),
		.resetn(resetn),
		.keySwitch(keySwitch),
		.cycle(st.cycle),
		.diagDone(diagDone),
		.diagStart(diagStart),
		.diagActive(diagActive),
		.taskQualify(taskQualify),
		.diagEvt(diagEvt)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence sBadgeRead;
		st.state == btgRead && badgeValid && inNormal && !badgeFault;
	endsequence

	sequence sHostAck;
		st.state == btgWait && ackWr && !badgeFault && inNormal;
	endsequence

	a_ready_off: assert property (badgeFull |=> !lamps.ready)
		else $error("ready lit with badge inserted");
	a_ready_on: assert property (st.state == btgReady && inNormal && !badgeFull &&
		!badgeFault |=> lamps.ready)
		else $error("ready not lit when idle");
	a_wait_hold: assert property (sBadgeRead ##1 (!ackWr && !badgeFault)[*2] |=>
		lamps.waitInd)
		else $error("wait lamp dropped before processing");
	a_wait_ready: assert property (sHostAck ##0 !badgeFull |=>
		lamps.ready && !lamps.waitInd)
		else $error("ready not next after wait");
	a_fault_lamps: assert property (faultEvt |=> !lamps.waitInd && lamps.error &&
		st.intStat[INT_FAULT])
		else $error("fault lamps wrong");
	a_error_stay: assert property (st.state == btgError && badgeFull && inNormal |=>
		lamps.error)
		else $error("error cleared before removal");
	a_key_idle: assert property (!inNormal && st.state != btgWait |=>
		!lamps.ready && !lamps.error)
		else $error("badge lamps active outside normal");
	a_badge_sent: assert property (sBadgeRead |=> st.badge == $past(badgeData) &&
		st.intStat[INT_BADGE] && st.state == btgWait)
		else $error("badge data not captured");
	a_prompt_pair: assert property (lamps.prompt |-> lamps.arrow && lamps.ready)
		else $error("prompt without arrow");
	a_irq_level: assert property (st.intStat[INT_FAULT] && st.intMask[INT_FAULT] |-> irq)
		else $error("masked-in status without interrupt");
endmodule

// File: verification/btg_host_model.sv
// Host-side APB master model of the guidance block
`timescale 1ns/100ps
module btg_host_model
	import btg_pkg::*;
(
	input wire logic clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output btg_apb_req_type apbReq
);
	initial begin
		apbReq = '0;
	end

	// One word per transfer, held until pready
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	task automatic set_time(input logic [15:0] t);
		logic [31:0] d;
		logic e;
		xfer(1'b1, OFF_TIME, {16'h0000, t}, d, e);
	endtask
endmodule

// File: verification/tb_badge_terminal_guidance_control.sv
// Self-checking bench of the badge terminal guidance block
`timescale 1ns/100ps
module tb_badge_terminal_guidance_control;
	import btg_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	btg_apb_req_type apbReq;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [1:0] keySwitch = 2'b00;
	logic badgeFull = 1'b0;
	logic badgeFault = 1'b0;
	logic badgeValid = 1'b0;
	logic [31:0] badgeData = 32'h0000_0000;
	logic diagDone = 1'b0;
	btg_lamp_type lamps;
	logic [15:0] timeDigits;
	logic diagStart;
	logic diagActive;
	logic taskQualify;
	logic irq;
	int n_fail = 0;
	int comparisons = 0;
	int nStarts = 0;
	int s0;

	btg_guidance_ctrl #(.BADGE_W(32), .MULTI_READER(1'b1)) btg_guidance_ctrl_i (.clk(clk),
		.resetn(resetn), .apbReq(apbReq), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .keySwitch(keySwitch), .badgeFull(badgeFull),
		.badgeFault(badgeFault), .badgeValid(badgeValid), .badgeData(badgeData),
		.diagDone(diagDone), .lamps(lamps), .timeDigits(timeDigits), .diagStart(diagStart),
		.diagActive(diagActive), .taskQualify(taskQualify), .irq(irq));
	btg_host_model host_i (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.apbReq(apbReq));

	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (diagStart === 1'b1) nStarts <= nStarts + 1;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		host_i.xfer(1'b0, a, 32'h0000_0000, d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		host_i.xfer(1'b1, a, d, x, e);
	endtask
	task automatic pulse_done;
		@(posedge clk);
		diagDone <= 1'b1;
		@(posedge clk);
		diagDone <= 1'b0;
	endtask

	task automatic t_reset;
		logic [31:0] d;
		settle(2);
		chk("ready", lamps.ready, 1'b1);
		chk("arrow", lamps.arrow, 1'b1);
		chk("prompt", lamps.prompt, 1'b1);
		chk("wait", lamps.waitInd, 1'b0);
		chk("time", timeDigits, 16'h0000);
		chk("pready", pready, 1'b1);
		rd(OFF_INT_MASK, d);
		chk("mask", d, 32'h0000_0000);
		$display("t_reset done");
	endtask

	task automatic t_badge;
		logic [31:0] d;
		wr(OFF_INT_MASK, 32'h0000_0001);
		@(posedge clk);
		badgeFull <= 1'b1;
		settle(2);
		chk("ready off", lamps.ready, 1'b0);
		chk("prompt off", lamps.prompt, 1'b0);
		@(posedge clk);
		badgeValid <= 1'b1;
		badgeData <= 32'hA5C3_0F96;
		@(posedge clk);
		badgeValid <= 1'b0;
		settle(2);
		chk("wait lit", lamps.waitInd, 1'b1);
		chk("irq", irq, 1'b1);
		rd(OFF_BADGE, d);
		chk("badge", d, 32'hA5C3_0F96);
		rd(OFF_INT_STAT, d);
		chk("badge event", d, 32'h0000_0001);
		@(posedge clk);
		badgeFull <= 1'b0;
		settle(3);
		chk("irq clear", irq, 1'b0);
		chk("wait held", lamps.waitInd, 1'b1);
		chk("ready held", lamps.ready, 1'b0);
		wr(OFF_CTRL, 32'h0000_0001);
		settle(2);
		chk("wait off", lamps.waitInd, 1'b0);
		chk("ready next", lamps.ready, 1'b1);
		$display("t_badge done");
	endtask

	task automatic t_fault;
		logic [31:0] d;
		@(posedge clk);
		badgeFull <= 1'b1;
		@(posedge clk);
		badgeFault <= 1'b1;
		@(posedge clk);
		badgeFault <= 1'b0;
		badgeValid <= 1'b1;
		@(posedge clk);
		badgeValid <= 1'b0;
		settle(2);
		chk("error lit", lamps.error, 1'b1);
		chk("no wait", lamps.waitInd, 1'b0);
		chk("masked irq", irq, 1'b0);
		rd(OFF_INT_STAT, d);
		chk("fault event", d, 32'h0000_0002);
		@(posedge clk);
		badgeFull <= 1'b0;
		settle(3);
		chk("error off", lamps.error, 1'b0);
		chk("ready back", lamps.ready, 1'b1);
		$display("t_fault done");
	endtask

	task automatic t_time;
		logic [31:0] d;
		logic e;
		host_i.set_time(16'h2359);
		settle(2);
		chk("time shown", timeDigits, 16'h2359);
		host_i.set_time(16'h2400);
		host_i.set_time(16'h1960);
		settle(2);
		chk("time kept", timeDigits, 16'h2359);
		rd(OFF_INT_STAT, d);
		chk("reject event", d, 32'h0000_0004);
		rd(OFF_TIME, d);
		chk("time reg", d, 32'h0000_2359);
		host_i.xfer(1'b0, 8'h40, 32'h0000_0000, d, e);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", d, 32'h0000_0000);
		$display("t_time done");
	endtask

	task automatic t_key;
		logic [31:0] d;
		@(posedge clk);
		keySwitch <= keyMaintenancePosition;
		s0 = nStarts;
		settle(4);
		chk("maintenance_position start", nStarts - s0, 1);
		chk("maintenance_position active", diagActive, 1'b1);
		pulse_done();
		settle(2);
		chk("maintenance_position end", diagActive, 1'b0);
		chk("single pass", nStarts - s0, 1);
		rd(OFF_INT_STAT, d);
		chk("diag event", d, 32'h0000_0008);
		@(posedge clk);
		keySwitch <= keyNormalPosition;
		wr(OFF_CTRL, 32'h0000_0002);
		@(posedge clk);
		keySwitch <= keySupervisorPosition;
		s0 = nStarts;
		settle(4);
		chk("no task", taskQualify, 1'b0);
		chk("cycle active", diagActive, 1'b1);
		pulse_done();
		settle(3);
		chk("cycle restart", nStarts - s0, 2);
		wr(OFF_CTRL, 32'h0000_0000);
		settle(1);
		chk("task qualify", taskQualify, 1'b1);
		@(posedge clk);
		badgeFull <= 1'b1;
		settle(2);
		rd(OFF_STATUS, d);
		chk("badge ignored", d[1:0], 2'b00);
		@(posedge clk);
		keySwitch <= keyNormalPosition;
		badgeFull <= 1'b0;
		settle(3);
		chk("diag abort", diagActive, 1'b0);
		chk("normal ready", lamps.ready, 1'b1);
		$display("t_key done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_badge();
		t_fault();
		t_time();
		t_key();
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
